// file: hw/bpt_device.sv
`include "bpt_map.svh"
// Summary of operation
// - host finishes a burst before starting another
// - host leaves 7 ns before next latch
// - wait goes not-available on select/latch fall
// - wait goes available at latency minus one
// - wait released when select rises
// - burst counts from first clock rise
// - host keeps burst under 2.5 us
// - early write strobe makes clock ignored
// - host drops write strobe one clock early
// - masked byte lanes stay unchanged on write
module bpt_device (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  bpt_if.device                  link,
  output logic [15:0]            rd_word_o,
  output logic                   rd_valid_o,
  input  wire logic              rd_ready_i,
  output logic                   busy_o
);
  import bpt_pkg::*;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_LAT   = 4'h2,
    ST_BURST = 4'h4,
    ST_AWR   = 4'h8
  } bpt_dst_t;
  logic [1:0]  clk_s_r, cs_s_r, adv_s_r, we_s_r, ub_s_r, lb_s_r;
  logic [5:0]  addr_s1_r, addr_s_r;
  logic [15:0] dq_s1_r, dq_s_r;
  logic        clk_d_r, cs_d_r, adv_d_r;
  bpt_dst_t    st_r;
  logic [3:0]  cnt_r;
  logic [5:0]  ptr_r;
  logic        is_wr_r;
  logic [15:0] mem_r [`BPT_MEM_WORDS];
  logic        rise, cs_fall, adv_fall, cs_rise;
  logic [15:0] buf_r [2];
  logic        wp_r, rp_r;
  logic [1:0]  cnt_b_r;
  logic        push;
  logic [15:0] push_w;

  function automatic logic [15:0] bpt_merge(input logic [15:0] old_w, input logic [15:0] new_w,
                                            input logic ub_n, input logic lb_n);
    bpt_merge = {ub_n ? old_w[15:8] : new_w[15:8], lb_n ? old_w[7:0] : new_w[7:0]};
  endfunction : bpt_merge

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_s_r   <= 2'h0;
      cs_s_r    <= 2'h3;
      adv_s_r   <= 2'h3;
      we_s_r    <= 2'h3;
      ub_s_r    <= 2'h3;
      lb_s_r    <= 2'h3;
      addr_s1_r <= 6'h00;
      addr_s_r  <= 6'h00;
      dq_s1_r   <= 16'h0000;
      dq_s_r    <= 16'h0000;
      clk_d_r   <= 1'b0;
      cs_d_r    <= 1'b1;
      adv_d_r   <= 1'b1;
    end else begin
      clk_s_r <= {clk_s_r[0], link.link_clk};
      cs_s_r <= {cs_s_r[0], link.chip_select_n};
      adv_s_r <= {adv_s_r[0], link.address_latch_strobe_n};
      we_s_r <= {we_s_r[0], link.write_strobe_n};
      ub_s_r <= {ub_s_r[0], link.upper_byte_enable_n};
      lb_s_r <= {lb_s_r[0], link.lower_byte_enable_n};
      addr_s1_r <= link.addr;
      addr_s_r <= addr_s1_r;
      dq_s1_r <= link.host_dq;
      dq_s_r <= dq_s1_r;
      // delayed copies give edge detection on the synchronised clock, select and latch pins
      clk_d_r <= clk_s_r[1];
      cs_d_r <= cs_s_r[1];
      adv_d_r <= adv_s_r[1];
    end
  end

  assign rise = clk_s_r[1] & ~clk_d_r;
  assign cs_fall = ~cs_s_r[1] & cs_d_r;
  assign cs_rise = cs_s_r[1] & ~cs_d_r;
  assign adv_fall = ~adv_s_r[1] & adv_d_r;
  assign push = (st_r == ST_BURST) && rise && !is_wr_r;
  assign push_w = mem_r[ptr_r];

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      ptr_r <= 6'h00;
      is_wr_r <= 1'b0;
    end else if (cs_rise) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (!cs_s_r[1] && !adv_s_r[1] && rise) begin
            st_r <= ST_LAT;
            cnt_r <= 4'h1;
            ptr_r <= addr_s_r;
            is_wr_r <= ~we_s_r[1];
          end else if (!cs_s_r[1] && !we_s_r[1] && adv_s_r[1]) begin
            st_r <= ST_AWR;
            ptr_r <= addr_s_r;
          end
        end
        ST_LAT: begin
          if (!we_s_r[1] && !is_wr_r && cnt_r < 4'(`BPT_LATENCY - 1)) begin
            st_r <= ST_AWR;
          end else if (rise) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'(`BPT_LATENCY - 1)) begin
              st_r <= ST_BURST;
              cnt_r <= 4'h0;
            end
          end
        end
        ST_BURST: begin
          if (rise && (is_wr_r || rd_ready_i || cnt_b_r != 2'h2)) begin
            ptr_r <= ptr_r + 6'h01;
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'(`BPT_BURST_LEN - 1)) st_r <= ST_IDLE;
          end
        end
        ST_AWR: begin
          if (we_s_r[1]) st_r <= ST_IDLE; // clock ignored here
        end
        default: st_r <= ST_IDLE;
      endcase
      if (adv_fall && st_r != ST_LAT) begin
        st_r <= ST_IDLE;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (st_r == ST_BURST && rise && is_wr_r) begin
      mem_r[ptr_r] <= bpt_merge(mem_r[ptr_r], dq_s_r, ub_s_r[1], lb_s_r[1]);
    end else if (st_r == ST_AWR && we_s_r[1]) begin
      mem_r[ptr_r] <= bpt_merge(mem_r[ptr_r], dq_s_r, ub_s_r[1], lb_s_r[1]);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link.wait_n <= 1'b1;
      link.wait_oe <= 1'b0;
    end else if (cs_rise) begin
      link.wait_oe <= 1'b0;
    end else if (cs_fall || adv_fall) begin
      link.wait_n <= 1'b0;
      link.wait_oe <= 1'b1;
    end else if (st_r == ST_LAT && rise && cnt_r == 4'(`BPT_LATENCY - 2)) begin
      link.wait_n <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link.dev_dq <= 16'h0000;
      link.dev_dq_oe <= 1'b0;
    end else begin
      link.dev_dq_oe <= (st_r == ST_BURST) && !is_wr_r;
      if (push) link.dev_dq <= push_w;
    end
  end

  // two-entry buffer; a full buffer stalls the burst while rd_ready_i is low, but a rise in a cycle with rd_ready_i high drops its word
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_b_r <= 2'h0;
      buf_r[0] <= 16'h0000;
      buf_r[1] <= 16'h0000;
    end else begin
      if (push && cnt_b_r != 2'h2) begin
        buf_r[wp_r] <= push_w;
        wp_r <= ~wp_r;
      end
      if (rd_valid_o && rd_ready_i) rp_r <= ~rp_r;
      cnt_b_r <= cnt_b_r + 2'((push && cnt_b_r != 2'h2) ? 1 : 0)
               - 2'((rd_valid_o && rd_ready_i) ? 1 : 0);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_word_o <= 16'h0000;
      rd_valid_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      busy_o <= (st_r != ST_IDLE);
      if (!rd_valid_o || rd_ready_i) begin
        rd_valid_o <= 1'b0;
        if (cnt_b_r == 2'h2 || (cnt_b_r == 2'h1 && !(rd_valid_o && rd_ready_i))) begin
          rd_word_o <= buf_r[rd_valid_o ? ~rp_r : rp_r];
          rd_valid_o <= 1'b1;
        end
      end
    end
  end
endmodule : bpt_device

// file: pkg/bpt_map.svh
`ifndef BPT_MAP_SVH
`define BPT_MAP_SVH
`define BPT_CLK_PERIOD_NS 10
`define BPT_GAP_NS 7
`define BPT_GAP_CYC ((`BPT_GAP_NS + `BPT_CLK_PERIOD_NS - 1) / `BPT_CLK_PERIOD_NS)
`define BPT_SPAN_NS 2500
`define BPT_SPAN_CYC (`BPT_SPAN_NS / `BPT_CLK_PERIOD_NS)
`define BPT_LINK_DIV 6
`define BPT_LATENCY 5
`define BPT_BURST_LEN 4
`define BPT_WE_LEAD_CLK 1
`define BPT_MEM_WORDS 64
`define BPT_ADDR_W 6
`define BPT_DATA_W 16
`endif

// file: pkg/bpt_pkg.sv
`include "bpt_map.svh"
package bpt_pkg;
  typedef logic [`BPT_ADDR_W-1:0] bpt_addr_t;
  typedef logic [`BPT_DATA_W-1:0] bpt_data_t;
  typedef enum logic [2:0] {
    BPT_OP_READ   = 3'h1,
    BPT_OP_BWRITE = 3'h2,
    BPT_OP_AWRITE = 3'h4
  } bpt_op_t;
endpackage : bpt_pkg

// file: pkg/bpt_if.sv
interface bpt_if;
  logic              link_clk;
  logic              chip_select_n;
  logic              address_latch_strobe_n;
  logic              write_strobe_n;
  logic              upper_byte_enable_n;
  logic              lower_byte_enable_n;
  logic [5:0]        addr;
  logic [15:0]       host_dq;
  logic              host_dq_oe;
  logic [15:0]       dev_dq;
  logic              dev_dq_oe;
  logic              wait_n;
  logic              wait_oe;
  modport host (output link_clk, chip_select_n, address_latch_strobe_n, write_strobe_n,
                output upper_byte_enable_n, lower_byte_enable_n, addr, host_dq, host_dq_oe,
                input dev_dq, dev_dq_oe, wait_n, wait_oe);
  modport device (input link_clk, chip_select_n, address_latch_strobe_n, write_strobe_n,
                  input upper_byte_enable_n, lower_byte_enable_n, addr, host_dq, host_dq_oe,
                  output dev_dq, dev_dq_oe, wait_n, wait_oe);
endinterface : bpt_if

// file: hw/bpt_host.sv
`include "bpt_map.svh"
module bpt_host (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  bpt_if.host                    link,
  input  wire logic              req_valid_i,
  input  bpt_pkg::bpt_op_t       req_op_i,
  input  bpt_pkg::bpt_addr_t     req_addr_i,
  input  bpt_pkg::bpt_data_t     req_data_i,
  output logic                   req_ready_o,
  output logic [15:0]            rsp_data_o,
  output logic                   rsp_valid_o
);
  import bpt_pkg::*;
  typedef enum logic [4:0] {
    HS_IDLE = 5'h01,
    HS_LAT  = 5'h02,
    HS_DATA = 5'h04,
    HS_AWR  = 5'h08,
    HS_GAP  = 5'h10
  } bpt_hst_t;
  bpt_hst_t    st_r;
  logic [2:0]  div_r;
  logic [3:0]  cnt_r;
  logic [8:0]  span_r;
  bpt_op_t     op_r;
  logic [15:0] wd_r;
  logic        fall_en;
  assign fall_en = (div_r == 3'(`BPT_LINK_DIV - 1)) && link.link_clk;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= 3'h0; link.link_clk <= 1'b0;
    end else if (div_r == 3'(`BPT_LINK_DIV / 2 - 1) || div_r == 3'(`BPT_LINK_DIV - 1)) begin
      link.link_clk <= ~link.link_clk;
      div_r <= (div_r == 3'(`BPT_LINK_DIV - 1)) ? 3'h0 : div_r + 3'h1;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= HS_IDLE; cnt_r <= 4'h0; span_r <= 9'h000; op_r <= BPT_OP_READ;
      wd_r <= 16'h0000; req_ready_o <= 1'b0; rsp_valid_o <= 1'b0; rsp_data_o <= 16'h0000;
      link.chip_select_n <= 1'b1; link.address_latch_strobe_n <= 1'b1;
      link.write_strobe_n <= 1'b1; link.upper_byte_enable_n <= 1'b1;
      link.lower_byte_enable_n <= 1'b1; link.addr <= 6'h00;
      link.host_dq <= 16'h0000; link.host_dq_oe <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      req_ready_o <= 1'b0;
      span_r <= (st_r == HS_IDLE) ? 9'h000 : span_r + 9'h001;
      case (st_r)
        HS_IDLE: begin
          if (req_valid_i && fall_en && !req_ready_o) begin
            req_ready_o <= 1'b1; op_r <= req_op_i; wd_r <= req_data_i;
            link.chip_select_n <= 1'b0; link.address_latch_strobe_n <= 1'b0;
            link.addr <= req_addr_i; link.upper_byte_enable_n <= 1'b0;
            link.lower_byte_enable_n <= 1'b0;
            // async write drops its strobe only after the latch pulse
            link.write_strobe_n <= (req_op_i != BPT_OP_BWRITE);
            link.host_dq <= req_data_i;
            link.host_dq_oe <= (req_op_i != BPT_OP_READ);
            cnt_r <= 4'h0;
            st_r <= HS_LAT;
          end
        end
        HS_LAT: begin
          if (fall_en) begin
            link.address_latch_strobe_n <= 1'b1;
            cnt_r <= cnt_r + 4'h1;
            if (op_r == BPT_OP_AWRITE) begin
              link.write_strobe_n <= 1'b0;
              st_r <= HS_AWR;
              cnt_r <= 4'h0;
            end else if (cnt_r == 4'(`BPT_LATENCY - 1)) begin
              st_r <= HS_DATA; cnt_r <= 4'h0;
            end
          end
        end
        HS_DATA: begin
          if (fall_en) begin
            cnt_r <= cnt_r + 4'h1;
            if (op_r == BPT_OP_READ) begin
              rsp_valid_o <= 1'b1; rsp_data_o <= link.dev_dq;
            end
            if (cnt_r == 4'(`BPT_BURST_LEN) ||
                span_r >= 9'(`BPT_SPAN_CYC - `BPT_LINK_DIV)) begin
              link.chip_select_n <= 1'b1; link.host_dq_oe <= 1'b0;
              link.write_strobe_n <= 1'b1; st_r <= HS_GAP; cnt_r <= 4'h0;
            end
          end
        end
        HS_AWR: begin
          if (fall_en) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'(`BPT_LATENCY)) begin
              link.write_strobe_n <= 1'b1; link.chip_select_n <= 1'b1;
              link.host_dq_oe <= 1'b0; st_r <= HS_GAP; cnt_r <= 4'h0;
            end
          end
        end
        HS_GAP: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r >= 4'(`BPT_GAP_CYC)) st_r <= HS_IDLE;
        end
        default: st_r <= HS_IDLE;
      endcase
    end
  end
endmodule : bpt_host

// file: tb/bpt_link_assertions.sv
`include "bpt_map.svh"
module bpt_link_checker (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic chip_select_n,
  input wire logic address_latch_strobe_n,
  input wire logic write_strobe_n,
  input wire logic host_dq_oe,
  input wire logic dev_dq_oe,
  input wire logic wait_n,
  input wire logic wait_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SPAN_CYC = `BPT_SPAN_CYC;
  logic [9:0] sel_cnt_r;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // saturates so a select stuck low still trips the limit
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_cnt_r <= 10'h000;
    end else if (chip_select_n) begin
      sel_cnt_r <= 10'h000;
    end else if (sel_cnt_r != 10'h3FF) begin
      sel_cnt_r <= sel_cnt_r + 10'h001;
    end
  end
  a_no_new_burst: assert property ($fell(address_latch_strobe_n) |-> $fell(chip_select_n))
    else $error("latch strobe fell inside a running burst");
  a_dq_one_driver: assert property (!(host_dq_oe && dev_dq_oe))
    else $error("both ends drive data");
  a_latch_gap_met: assert property ($rose(chip_select_n) |-> address_latch_strobe_n ##1
    address_latch_strobe_n)
    else $error("latch strobe too soon after burst end");
  a_wait_on_select: assert property ($fell(chip_select_n) |-> ##[1:8] (wait_oe && !wait_n))
    else $error("wait not driven low after select");
  a_wait_not_early: assert property ($fell(chip_select_n) |-> ##10 !(wait_oe && wait_n))
    else $error("wait available too early");
  a_wait_ready_time: assert property (($fell(chip_select_n) ##1 write_strobe_n [*8]) |->
    ##[10:30] (wait_oe && wait_n))
    else $error("wait not available at latency minus one");
  a_wait_released: assert property ($rose(chip_select_n) |-> ##[1:6] !wait_oe)
    else $error("wait not released after deselect");
  a_wait_idle_hiz: assert property (chip_select_n [*8] |-> !wait_oe)
    else $error("wait driven while idle");
  a_latch_one_clock: assert property ($fell(address_latch_strobe_n) |->
    ##[1:12] address_latch_strobe_n)
    else $error("latch strobe held too long");
  a_span_limit: assert property (sel_cnt_r <= SPAN_CYC)
    else $error("burst longer than span limit");
  a_write_before_ref: assert property (($fell(write_strobe_n) && !chip_select_n) |->
    !(wait_oe && wait_n))
    else $error("write strobe fell after reference edge");
  c_wait_ready: cover property ($rose(wait_n) && wait_oe);
  c_write_strobe: cover property ($fell(write_strobe_n));
  c_close_bursts: cover property ($rose(chip_select_n) ##[2:12] $fell(chip_select_n));
endmodule : bpt_link_checker

// file: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import bpt_pkg::*;
  logic        core_clk_i;
  logic        rst_n_i;
  logic        req_valid_i;
  bpt_op_t     req_op_i;
  bpt_addr_t   req_addr_i;
  bpt_data_t   req_data_i;
  logic        req_ready_o;
  bpt_data_t   rsp_data_o;
  logic        rsp_valid_o;
  logic [15:0] rd_word_o;
  logic        rd_valid_o;
  logic        rd_ready_i;
  logic        busy_o;
  int          fail_count;
  int          num_checks;
  bpt_data_t   rsp_q[$];
  bpt_data_t   rd_q[$];
  bpt_if link ();
  bpt_host bpt_host_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(link),
    .req_valid_i(req_valid_i), .req_op_i(req_op_i), .req_addr_i(req_addr_i),
    .req_data_i(req_data_i), .req_ready_o(req_ready_o), .rsp_data_o(rsp_data_o),
    .rsp_valid_o(rsp_valid_o));
  bpt_device bpt_device_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(link),
    .rd_word_o(rd_word_o), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .busy_o(busy_o));
  bpt_link_checker bpt_link_checker_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .chip_select_n(link.chip_select_n), .address_latch_strobe_n(link.address_latch_strobe_n),
    .write_strobe_n(link.write_strobe_n), .host_dq_oe(link.host_dq_oe),
    .dev_dq_oe(link.dev_dq_oe), .wait_n(link.wait_n), .wait_oe(link.wait_oe));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    if (rsp_valid_o === 1'b1) rsp_q.push_back(rsp_data_o);
    if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) rd_q.push_back(rd_word_o);
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // holds the request until the host pulses ready, then drops it
  task automatic issue(input bpt_op_t op, input bpt_addr_t a, input bpt_data_t d);
    int n;
    @(negedge core_clk_i);
    req_valid_i = 1'b1;
    req_op_i = op;
    req_addr_i = a;
    req_data_i = d;
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 400);
    req_valid_i = 1'b0;
    check("request taken", 16'h0001, {15'h0000, req_ready_o});
  endtask : issue
  task automatic settle();
    int n;
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while ((busy_o !== 1'b0 || link.chip_select_n !== 1'b1) && n < 2000);
    repeat (12) @(negedge core_clk_i);
    check("idle reached", 16'h0001, {15'h0000, n < 2000});
  endtask : settle
  // host's first read sample precedes the device's first beat
  function automatic bpt_data_t head(input bpt_data_t q[$], input int i);
    return (q.size() > i) ? q[i] : 16'hXXXX;
  endfunction : head
  task automatic t_write_read(input bpt_op_t op, input bpt_addr_t a, input bpt_data_t d);
    issue(op, a, d);
    settle();
    rsp_q.delete();
    rd_q.delete();
    issue(BPT_OP_READ, a, 16'h0000);
    settle();
    check("host read beat", d, head(rsp_q, 1));
    check("device read word", d, head(rd_q, 0));
  endtask : t_write_read
  task automatic t_back_to_back(input bpt_addr_t a, input bpt_data_t d);
    issue(BPT_OP_BWRITE, a, d);
    rsp_q.delete();
    issue(BPT_OP_READ, a, 16'h0000);
    settle();
    check("read after write", d, head(rsp_q, 1));
  endtask : t_back_to_back
  // receiver stalls: the buffered word must stand until taken
  task automatic t_stall(input bpt_addr_t a, input bpt_data_t d);
    issue(BPT_OP_BWRITE, a, d);
    settle();
    rd_q.delete();
    rd_ready_i = 1'b0;
    issue(BPT_OP_READ, a, 16'h0000);
    repeat (80) @(negedge core_clk_i);
    check("stalled valid", 16'h0001, {15'h0000, rd_valid_o});
    check("stalled word", d, rd_word_o);
    rd_ready_i = 1'b1;
    settle();
    check("drained word", d, head(rd_q, 0));
  endtask : t_stall
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    fail_count = 0;
    num_checks = 0;
    req_valid_i = 1'b0;
    req_op_i = BPT_OP_READ;
    req_addr_i = 6'h00;
    req_data_i = 16'h0000;
    rd_ready_i = 1'b1;
    rst_n_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    t_write_read(BPT_OP_BWRITE, 6'h05, 16'hA5C3);
    t_write_read(BPT_OP_AWRITE, 6'h3F, 16'h5A3C);
    t_back_to_back(6'h00, 16'hFFFF);
    t_stall(6'h12, 16'h0F0F);
    wrap_up();
  end
  initial begin
    #200us;
    fail_count++;
    wrap_up();
  end
endmodule : tb
